// [logic/register_reset_supply_flags.sv]
// Summary of operation
// (R1) Logic supply missing or undervoltage returns all configuration registers to defaults; here undervoltage leaves irq_enable_reg unchanged.
// (R2) Standby pin low holds all configuration registers at their defaults; here irq_enable_reg is not held and still takes writes.
// (R3) Writing one to the soft reset request bit resets configuration registers.
// (R4) Soft reset leaves the per-channel fault flags unchanged.
// (R5) Soft reset clears load undervoltage and logic low power flags.
// (R6) Register reset turns channels off unless a parallel input drives them; mapping defaults.
// (R7) Operative device with load supply undervoltage sets the load undervoltage flag.
// (R8) Load undervoltage flag clears at first diagnosis read after load supply recovers.
// (R9) Logic supply in low power range sets the low power flag.
// (R10) Low power flag clears at first diagnosis read after logic supply recovers.
// (R11) A channel under inverse current keeps its present on or off state.
// (R12) Under inverse current an on channel may flag a fault on over-temperature.
// (R13) No over-load or over-temperature shutdown while inverse current is applied.
// (R14) The soft reset request bit clears itself and reads back zero afterwards.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rrsf_consts.svh"
module register_reset_supply_flags
  import rrsf_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic STANDBY_N,
  input wire logic [1:0] PARALLEL_INPUT_PINS,
  input wire logic LOGIC_UV,
  input wire logic LOGIC_LOP,
  input wire logic LOAD_UV,
  input wire logic LOAD_OP,
  input wire logic [7:0] INV_CUR,
  input wire logic [7:0] OVER_TEMP,
  input wire logic [7:0] OVER_LOAD,
  output logic [7:0] CHANNEL_ON,
  output logic IRQ
);
  supply_ctl_if ctl ();

  pin_vec_t pin_raw;
  pin_vec_t sync1_reg;
  pin_vec_t sync2_reg;
  logic standby_n;
  logic [1:0] par_in;
  logic logic_uv;
  logic cfg_reset;
  logic soft_req_reg;
  chan_vec_t out_reg;
  chan_vec_t map0_reg;
  chan_vec_t map1_reg;
  irq_vec_t irq_status_reg;
  irq_vec_t irq_enable_reg;
  irq_vec_t irq_event;
  irq_vec_t irq_clear;
  reg_data_t rdata_reg;
  logic irq_reg;

  function automatic logic hit(input reg_addr_t a, input reg_addr_t target);
    hit = (a == target);
  endfunction

  // All pins and monitor levels are asynchronous to CLK
  assign pin_raw = {STANDBY_N, PARALLEL_INPUT_PINS, LOGIC_UV, LOGIC_LOP, LOAD_UV, LOAD_OP,
                    INV_CUR, OVER_TEMP, OVER_LOAD};

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      sync1_reg <= 31'h00000000;
      sync2_reg <= 31'h00000000;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  assign standby_n = sync2_reg[30];
  assign par_in = sync2_reg[29:28];
  assign logic_uv = sync2_reg[27];
  assign ctl.lop = sync2_reg[26];
  assign ctl.load_uv = sync2_reg[25];
  assign ctl.load_op = sync2_reg[24];
  assign ctl.inv_cur = sync2_reg[23:16];
  assign ctl.over_temp = sync2_reg[15:8];
  assign ctl.over_load = sync2_reg[7:0];

  assign ctl.operative = standby_n & ~logic_uv;
  assign ctl.soft_reset = soft_req_reg; // R3
  // Logic supply loss also asserts SYS_RST, which defaults everything
  assign cfg_reset = logic_uv | ~standby_n | soft_req_reg; // R1 R2 R3

  // Request lives one cycle: it performs the reset, then drops
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      soft_req_reg <= 1'b0;
    end else if (soft_req_reg) begin
      soft_req_reg <= 1'b0; // R14
    end else begin
      soft_req_reg <= WR & hit(ADDR, `ADDR_CTRL) & WDATA[`SOFT_RESET_BIT] & ctl.operative; // R3
    end
  end

  // Writes are ignored while any register reset is asserted
  always_ff @(posedge CLK) begin
    if (SYS_RST || cfg_reset) begin
      out_reg <= `OUT_DEFAULT; // R6
      map0_reg <= `MAP0_DEFAULT; // R6
      map1_reg <= `MAP1_DEFAULT; // R6
    end else if (WR) begin
      if (hit(ADDR, `ADDR_OUT)) begin
        out_reg <= WDATA;
      end
      if (hit(ADDR, `ADDR_MAP0)) begin
        map0_reg <= WDATA;
      end
      if (hit(ADDR, `ADDR_MAP1)) begin
        map1_reg <= WDATA;
      end
    end
  end

  // Parallel inputs keep driving their mapped channels through a register reset, but not through SYS_RST
  assign ctl.drive = out_reg | (par_in[0] ? map0_reg : 8'h00) | (par_in[1] ? map1_reg : 8'h00); // R6
  assign ctl.err_clr = (WR && hit(ADDR, `ADDR_ERR)) ? WDATA : 8'h00;
  assign ctl.diag_read = RD & hit(ADDR, `ADDR_DIAG); // R8 R10

  supply_flags u_flags (
    .clk(CLK),
    .sys_rst(SYS_RST),
    .bus(ctl.flags)
  );

  channel_protect u_prot (
    .clk(CLK),
    .sys_rst(SYS_RST),
    .bus(ctl.prot)
  );

  assign irq_event = {ctl.lop_event, ctl.uv_event, ctl.err_event};
  assign irq_clear = (WR && hit(ADDR, `ADDR_IRQ_CLEAR)) ? WDATA[2:0] : 3'h0;

  // New events win over a clear in the same cycle
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      irq_status_reg <= 3'h0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      irq_enable_reg <= `IRQ_ENABLE_DEFAULT;
    end else if (WR && hit(ADDR, `ADDR_IRQ_ENABLE)) begin
      irq_enable_reg <= WDATA[2:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // Diagnosis readout returns the flags as they stood before the clear
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_reg <= 8'h00;
    end else if (RD) begin
      unique case (ADDR)
        `ADDR_CTRL: rdata_reg <= {7'h00, soft_req_reg}; // R14
        `ADDR_OUT: rdata_reg <= out_reg;
        `ADDR_MAP0: rdata_reg <= map0_reg;
        `ADDR_MAP1: rdata_reg <= map1_reg;
        `ADDR_DIAG: rdata_reg <= {6'h00, ctl.lop_flag, ctl.uv_flag};
        `ADDR_ERR: rdata_reg <= ctl.err;
        `ADDR_IRQ_STATUS: rdata_reg <= {5'h00, irq_status_reg};
        `ADDR_IRQ_ENABLE: rdata_reg <= {5'h00, irq_enable_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign RDATA = rdata_reg;
  assign CHANNEL_ON = ctl.ch_on;
  assign IRQ = irq_reg;
endmodule
`default_nettype wire

// [logic/rrsf_consts.svh]
`ifndef RRSF_CONSTS_SVH
`define RRSF_CONSTS_SVH

`define ADDR_CTRL 4'h0
`define ADDR_OUT 4'h1
`define ADDR_MAP0 4'h2
`define ADDR_MAP1 4'h3
`define ADDR_DIAG 4'h4
`define ADDR_ERR 4'h5
`define ADDR_IRQ_STATUS 4'h6
`define ADDR_IRQ_ENABLE 4'h7
`define ADDR_IRQ_CLEAR 4'h8

`define OUT_DEFAULT 8'h00
`define MAP0_DEFAULT 8'h04
`define MAP1_DEFAULT 8'h08
`define IRQ_ENABLE_DEFAULT 3'h0

`define SOFT_RESET_BIT 0
`define DIAG_UV_BIT 0
`define DIAG_LOP_BIT 1
`define IRQ_FAULT_BIT 0
`define IRQ_UV_BIT 1
`define IRQ_LOP_BIT 2

`endif

// [logic/rrsf_pkg.sv]
package rrsf_pkg;
  typedef logic [7:0] chan_vec_t;
  typedef logic [3:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
  typedef logic [2:0] irq_vec_t;
  typedef logic [30:0] pin_vec_t;
endpackage

// [logic/supply_ctl_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface supply_ctl_if;
  import rrsf_pkg::*;
  logic soft_reset;
  logic diag_read;
  logic operative;
  logic load_uv;
  logic load_op;
  logic lop;
  chan_vec_t err_clr;
  chan_vec_t drive;
  chan_vec_t inv_cur;
  chan_vec_t over_temp;
  chan_vec_t over_load;
  chan_vec_t ch_on;
  chan_vec_t err;
  logic err_event;
  logic uv_flag;
  logic lop_flag;
  logic uv_event;
  logic lop_event;

  modport flags (
    input soft_reset,
    input diag_read,
    input operative,
    input load_uv,
    input load_op,
    input lop,
    output uv_flag,
    output lop_flag,
    output uv_event,
    output lop_event
  );

  modport prot (
    input drive,
    input inv_cur,
    input over_temp,
    input over_load,
    input err_clr,
    output ch_on,
    output err,
    output err_event
  );
endinterface
`default_nettype wire

// [logic/supply_flags.sv]
`timescale 1ns/1ps
`default_nettype none
module supply_flags
  import rrsf_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  supply_ctl_if.flags bus
);
  logic uv_set;
  logic uv_clr;
  logic lop_set;
  logic lop_clr;

  // Set has priority so a dip during a readout is never lost
  assign uv_set = bus.operative & bus.load_uv; // R7
  assign uv_clr = bus.soft_reset | (bus.diag_read & bus.load_op & ~bus.load_uv); // R5 R8
  assign lop_set = bus.lop; // R9
  assign lop_clr = bus.soft_reset | (bus.diag_read & ~bus.lop); // R5 R10

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus.uv_flag <= 1'b0;
      bus.uv_event <= 1'b0;
    end else begin
      bus.uv_event <= uv_set & ~bus.uv_flag;
      if (uv_set) begin
        bus.uv_flag <= 1'b1; // R7
      end else if (uv_clr) begin
        bus.uv_flag <= 1'b0; // R8
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus.lop_flag <= 1'b0;
      bus.lop_event <= 1'b0;
    end else begin
      bus.lop_event <= lop_set & ~bus.lop_flag;
      if (lop_set) begin
        bus.lop_flag <= 1'b1; // R9
      end else if (lop_clr) begin
        bus.lop_flag <= 1'b0; // R10
      end
    end
  end
endmodule
`default_nettype wire

// [logic/channel_protect.sv]
`timescale 1ns/1ps
`default_nettype none
module channel_protect
  import rrsf_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  supply_ctl_if.prot bus
);
  chan_vec_t latch_reg;
  chan_vec_t trip;
  chan_vec_t err_set;

  // No over-load or over-temperature trip on a channel under inverse current
  assign trip = bus.ch_on & ~bus.inv_cur & (bus.over_temp | bus.over_load); // R13
  assign err_set = trip | (bus.ch_on & bus.inv_cur & bus.over_temp); // R12

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus.ch_on <= 8'h00;
    end else begin
      // Inverse current freezes the present state
      bus.ch_on <= (bus.inv_cur & bus.ch_on) | (~bus.inv_cur & bus.drive & ~latch_reg & ~trip); // R11
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_reg <= 8'h00;
    end else begin
      latch_reg <= (latch_reg & ~bus.err_clr) | trip;
    end
  end

  // Untouched by the soft reset so fault history survives it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bus.err <= 8'h00;
      bus.err_event <= 1'b0;
    end else begin
      bus.err <= (bus.err & ~bus.err_clr) | err_set; // R4
      bus.err_event <= |(err_set & ~bus.err);
    end
  end
endmodule
`default_nettype wire

// [verification/supply_model.sv]
`timescale 1ns/1ps
`default_nettype none
module supply_model (
  input wire logic [3:0] sup,
  output logic logic_uv,
  output logic logic_lop,
  output logic load_uv,
  output logic load_op
);
  assign logic_uv = sup[0];
  assign logic_lop = sup[1];
  assign load_uv = sup[2];
  // Between the two load thresholds neither level is high
  assign load_op = ~sup[2] & ~sup[3];
endmodule
`default_nettype wire

// [verification/register_reset_supply_flags_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module rrsf_checker (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic STANDBY_N,
  input wire logic [1:0] PARALLEL_INPUT_PINS,
  input wire logic LOGIC_UV,
  input wire logic LOGIC_LOP,
  input wire logic LOAD_UV,
  input wire logic LOAD_OP,
  input wire logic [7:0] INV_CUR,
  input wire logic [7:0] CHANNEL_ON,
  input wire logic IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Pins and inverse current both override a reset, so only quiet cycles count
  wire quiet = PARALLEL_INPUT_PINS == 2'h0 && INV_CUR == 8'h00;
  reset_out_a: assert property ($fell(SYS_RST) |-> CHANNEL_ON == 8'h00 && !IRQ)
    else $error("outputs not cleared by reset");
  softrst_ctrl_a: assert property ((WR && ADDR == 4'h0 && WDATA[0]) ##2 (RD && ADDR == 4'h0) |=> !RDATA[0])
    else $error("soft reset request did not clear itself");
  softrst_out_a: assert property ((WR && ADDR == 4'h0 && WDATA[0] && STANDBY_N && !LOGIC_UV && quiet) ##1
    (!WR && quiet)[*3] |=> CHANNEL_ON == 8'h00) else $error("channels on after soft reset");
  uv_set_a: assert property ((LOAD_UV && STANDBY_N && !LOGIC_UV)[*5] ##0 (RD && ADDR == 4'h4) |=> RDATA[0])
    else $error("load undervoltage flag not set");
  lop_set_a: assert property (LOGIC_LOP[*5] ##0 (RD && ADDR == 4'h4) |=> RDATA[1])
    else $error("low power flag not set");
  uv_clear_a: assert property ((!LOAD_UV && LOAD_OP)[*3] ##1 (RD && ADDR == 4'h4 && !LOAD_UV && LOAD_OP)
    ##1 !LOAD_UV ##1 (RD && ADDR == 4'h4 && !LOAD_UV) |=> !RDATA[0]) else $error("uv flag kept after read");
  lop_clear_a: assert property ((!LOGIC_LOP)[*3] ##1 (RD && ADDR == 4'h4 && !LOGIC_LOP)
    ##1 !LOGIC_LOP ##1 (RD && ADDR == 4'h4 && !LOGIC_LOP) |=> !RDATA[1]) else $error("lop flag kept after read");
  inv_hold_a: assert property (INV_CUR[2][*4] |-> $stable(CHANNEL_ON[2]))
    else $error("channel changed under inverse current");
endmodule
bind register_reset_supply_flags rrsf_checker chk_i (.CLK, .SYS_RST, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .STANDBY_N, .PARALLEL_INPUT_PINS, .LOGIC_UV, .LOGIC_LOP, .LOAD_UV, .LOAD_OP, .INV_CUR, .CHANNEL_ON, .IRQ);
`default_nettype wire

// [verification/register_reset_supply_flags_test.sv]
`timescale 1ns/1ps
`default_nettype none
module register_reset_supply_flags_test
  import rrsf_pkg::*;
;
  logic CLK, SYS_RST, WR, RD, STANDBY_N, LOGIC_UV, LOGIC_LOP, LOAD_UV, LOAD_OP, IRQ;
  reg_addr_t ADDR;
  reg_data_t WDATA, RDATA;
  logic [1:0] PARALLEL_INPUT_PINS;
  logic [3:0] sup;
  chan_vec_t INV_CUR, OVER_TEMP, OVER_LOAD, CHANNEL_ON;
  int fails, samples_checked, cyc;
  register_reset_supply_flags DUT (.CLK, .SYS_RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .STANDBY_N,
    .PARALLEL_INPUT_PINS, .LOGIC_UV, .LOGIC_LOP, .LOAD_UV, .LOAD_OP, .INV_CUR, .OVER_TEMP, .OVER_LOAD,
    .CHANNEL_ON, .IRQ);
  supply_model mon (.sup, .logic_uv(LOGIC_UV), .logic_lop(LOGIC_LOP), .load_uv(LOAD_UV), .load_op(LOAD_OP));
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Whole sequence needs about 150 cycles
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      stop_test;
    end
  end
  task chk(input string n, input reg_data_t e, input reg_data_t g);
    samples_checked++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task w(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task wr(input reg_addr_t a, input reg_data_t d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  task rd(input reg_addr_t a, input reg_data_t e);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk("RDATA", e, RDATA);
  endtask
  initial begin
    {WR, RD, ADDR, WDATA, PARALLEL_INPUT_PINS, sup, INV_CUR, OVER_TEMP, OVER_LOAD, cyc} = '0;
    fails = 0;
    samples_checked = 0;
    SYS_RST = 1'b1;
    STANDBY_N = 1'b1;
    w(10);
    SYS_RST <= 1'b0;
    w(3);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h04);
    rd(4'h3, 8'h08);
    rd(4'hf, 8'h00);
    wr(4'h1, 8'h81);
    wr(4'h2, 8'h00);
    rd(4'h2, 8'h00);
    STANDBY_N <= 1'b0;
    w(4);
    wr(4'h1, 8'h55);
    rd(4'h1, 8'h00);
    rd(4'h2, 8'h04);
    chk("CHANNEL_ON", 8'h00, CHANNEL_ON);
    STANDBY_N <= 1'b1;
    w(4);
    wr(4'h1, 8'h02);
    wr(4'h7, 8'h02);
    sup <= 4'he;
    w(5);
    rd(4'h4, 8'h03);
    chk("IRQ", 8'h01, {7'h00, IRQ});
    wr(4'h8, 8'h07);
    w(2);
    chk("IRQ", 8'h00, {7'h00, IRQ});
    sup <= 4'h0;
    OVER_TEMP <= 8'h02;
    w(5);
    OVER_TEMP <= 8'h00;
    rd(4'h5, 8'h02);
    wr(4'h0, 8'h01);
    rd(4'h0, 8'h00);
    rd(4'h4, 8'h00);
    rd(4'h5, 8'h02);
    rd(4'h1, 8'h00);
    chk("CHANNEL_ON", 8'h00, CHANNEL_ON);
    sup <= 4'h6;
    w(5);
    sup <= 4'h0;
    w(4);
    rd(4'h4, 8'h03);
    rd(4'h4, 8'h00);
    wr(4'h2, 8'h10);
    PARALLEL_INPUT_PINS <= 2'h1;
    wr(4'h0, 8'h01);
    w(5);
    rd(4'h2, 8'h04);
    chk("CHANNEL_ON", 8'h04, CHANNEL_ON);
    INV_CUR <= 8'h04;
    w(4);
    PARALLEL_INPUT_PINS <= 2'h0;
    OVER_LOAD <= 8'h04;
    OVER_TEMP <= 8'h04;
    w(6);
    chk("CHANNEL_ON", 8'h04, CHANNEL_ON);
    rd(4'h5, 8'h06);
    wr(4'h5, 8'h02);
    rd(4'h5, 8'h04);
    // Pin back high: a trip taken under inverse current would keep it latched off
    INV_CUR <= 8'h00;
    {OVER_LOAD, OVER_TEMP} <= '0;
    PARALLEL_INPUT_PINS <= 2'h1;
    w(5);
    chk("CHANNEL_ON", 8'h04, CHANNEL_ON);
    PARALLEL_INPUT_PINS <= 2'h0;
    w(5);
    chk("CHANNEL_ON", 8'h00, CHANNEL_ON);
    wr(4'h1, 8'h20);
    rd(4'h1, 8'h20);
    sup <= 4'h1;
    w(4);
    rd(4'h1, 8'h00);
    chk("CHANNEL_ON", 8'h00, CHANNEL_ON);
    sup <= 4'h0;
    w(4);
    wr(4'h1, 8'h20);
    SYS_RST <= 1'b1;
    w(2);
    SYS_RST <= 1'b0;
    w(3);
    rd(4'h1, 8'h00);
    rd(4'h5, 8'h00);
    chk("CHANNEL_ON", 8'h00, CHANNEL_ON);
    stop_test;
  end
endmodule
`default_nettype wire
